// ===== hw/pressure_switch_menu.sv
// Button menu, settings store and two switching outputs with an Avalon-MM slave.
// Buttons are asynchronous pins, active high; pressure comes from logic on ref_clk.
`timescale 1ns/1ps
`include "switch_menu_regs.svh"
module pressure_switch_menu
#(
    parameter int FULL_SCALE = 10000,
    parameter int RANGE_LOW = 0,
    parameter bit VACUUM_RANGE = 1'b0,
    parameter int LEVEL_STEP = 1,
    parameter int HOLD_CYCLES = `SET_HOLD_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire switch_menu_pkg::button_type buttons,
    input wire switch_menu_pkg::level_type pressure_level,
    output logic first_output,
    output logic second_output,
    output switch_menu_pkg::display_type display
);
    localparam int HYST_MIN = FULL_SCALE * `HYST_MIN_PERMILLE / 1000;
    localparam int ANALOG_SPAN = (FULL_SCALE - RANGE_LOW) * `ANALOG_SPAN_MIN_PCT / 100;
    localparam switch_menu_pkg::level_type TRIP_DEFAULT =
        switch_menu_pkg::level_type'(FULL_SCALE * `TRIP_DEFAULT_PCT / 100);
    localparam switch_menu_pkg::level_type RELEASE_DEFAULT =
        switch_menu_pkg::level_type'(FULL_SCALE * `RELEASE_DEFAULT_PCT / 100);
    localparam switch_menu_pkg::level_type START_DEFAULT =
        VACUUM_RANGE ? 16'shFFFF : 16'sh0000;
    localparam switch_menu_pkg::level_type END_DEFAULT =
        switch_menu_pkg::level_type'(FULL_SCALE);
    localparam logic [27:0] HOLD_LAST = 28'(HOLD_CYCLES - 1);

    typedef struct packed {
        switch_menu_pkg::button_type sync1;
        switch_menu_pkg::button_type sync2;
        switch_menu_pkg::button_type prev;
        switch_menu_pkg::settings_type settings;
        switch_menu_pkg::menu_item_type item;
        switch_menu_pkg::menu_mode_type mode;
        logic [27:0] hold_count;
        logic hold_done;
        switch_menu_pkg::level_type edit_level;
        logic ack;
        logic [31:0] rdata;
    } state_type;

    state_type state_reg;
    state_type state_next;

    function automatic switch_menu_pkg::level_type item_value(
        input switch_menu_pkg::settings_type s,
        input switch_menu_pkg::menu_item_type it
    );
        switch_menu_pkg::level_type v;
        v = '0;
        case (it)
            switch_menu_pkg::item_lock: v = 16'(s.menu_editable_state);
            switch_menu_pkg::item_first_function: v = 16'(s.first_output_function);
            switch_menu_pkg::item_first_trip: v = s.first_trip_level;
            switch_menu_pkg::item_first_release: v = s.first_release_level;
            switch_menu_pkg::item_first_window_high: v = s.first_window_high;
            switch_menu_pkg::item_first_window_low: v = s.first_window_low;
            switch_menu_pkg::item_second_function: v = 16'(s.second_output_function);
            switch_menu_pkg::item_second_trip: v = s.second_trip_level;
            switch_menu_pkg::item_second_release: v = s.second_release_level;
            switch_menu_pkg::item_second_window_high: v = s.second_window_high;
            switch_menu_pkg::item_second_window_low: v = s.second_window_low;
            switch_menu_pkg::item_analog_start: v = s.analog_start_level;
            switch_menu_pkg::item_analog_end: v = s.analog_end_level;
            default: v = '0;
        endcase
        return v;
    endfunction : item_value

    // Keeps a trip/release pair apart by the least hysteresis
    function automatic switch_menu_pkg::level_type release_limit(
        input switch_menu_pkg::level_type trip,
        input switch_menu_pkg::level_type rel
    );
        int lim;
        lim = int'(trip) - HYST_MIN;
        return (int'(rel) > lim) ? 16'(lim) : rel; // R18 R19
    endfunction : release_limit

    function automatic switch_menu_pkg::settings_type store_value(
        input switch_menu_pkg::settings_type s,
        input switch_menu_pkg::menu_item_type it,
        input switch_menu_pkg::level_type v
    );
        switch_menu_pkg::settings_type r;
        r = s;
        case (it)
            switch_menu_pkg::item_lock: r.menu_editable_state = v[0];
            switch_menu_pkg::item_first_function:
                r.first_output_function = switch_menu_pkg::function_type'(v[1:0]); // R08
            switch_menu_pkg::item_first_trip:
            begin
                r.first_trip_level = v;
                r.first_release_level = release_limit(v, s.first_release_level); // R19
            end
            switch_menu_pkg::item_first_release:
                r.first_release_level = release_limit(s.first_trip_level, v); // R18
            switch_menu_pkg::item_first_window_high: r.first_window_high = v;
            switch_menu_pkg::item_first_window_low: r.first_window_low = v;
            switch_menu_pkg::item_second_function:
                r.second_output_function = switch_menu_pkg::function_type'(v[1:0]); // R12
            switch_menu_pkg::item_second_trip:
            begin
                r.second_trip_level = v;
                r.second_release_level = release_limit(v, s.second_release_level); // R19
            end
            switch_menu_pkg::item_second_release:
                r.second_release_level = release_limit(s.second_trip_level, v); // R18
            switch_menu_pkg::item_second_window_high: r.second_window_high = v;
            switch_menu_pkg::item_second_window_low: r.second_window_low = v;
            switch_menu_pkg::item_analog_start:
                r.analog_start_level = (int'(v) > int'(s.analog_end_level) - ANALOG_SPAN) ?
                    16'(int'(s.analog_end_level) - ANALOG_SPAN) : v; // R20
            switch_menu_pkg::item_analog_end:
                r.analog_end_level = (int'(v) < int'(s.analog_start_level) + ANALOG_SPAN) ?
                    16'(int'(s.analog_start_level) + ANALOG_SPAN) : v; // R20
            default: r = s;
        endcase
        return r;
    endfunction : store_value

    // Choices wrap around; levels stop at the range ends
    function automatic switch_menu_pkg::level_type step_value(
        input switch_menu_pkg::menu_item_type it,
        input switch_menu_pkg::level_type v,
        input logic up
    );
        int n;
        int top;
        top = FULL_SCALE;
        n = up ? int'(v) + LEVEL_STEP : int'(v) - LEVEL_STEP;
        if (it == switch_menu_pkg::item_lock)
        begin
            n = up ? ((int'(v) + 1) % 2) : ((int'(v) + 1) % 2);
        end
        else if (it == switch_menu_pkg::item_first_function
            || it == switch_menu_pkg::item_second_function)
        begin
            n = up ? ((int'(v) + 1) % 4) : ((int'(v) + 3) % 4);
        end
        else if (n > top)
        begin
            n = top;
        end
        else if (n < RANGE_LOW)
        begin
            n = RANGE_LOW;
        end
        return 16'(n);
    endfunction : step_value

    always_comb
    begin
        switch_menu_pkg::button_type press;
        logic set_release;
        logic edit_allowed;
        logic req;
        state_next = state_reg;
        state_next.sync1 = buttons;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        press = state_reg.sync2 & ~state_reg.prev;
        set_release = state_reg.prev.set & ~state_reg.sync2.set;
        edit_allowed = state_reg.settings.menu_editable_state
            || state_reg.item == switch_menu_pkg::item_lock; // R07
        req = read | write;

        if (press.mode)
        begin
            // Edit is abandoned and the stored value stays
            if (state_reg.mode == switch_menu_pkg::editing
                || state_reg.mode == switch_menu_pkg::in_submenu)
            begin
                state_next.mode = switch_menu_pkg::show_name; // R23
            end
            else
            begin
                state_next.mode = switch_menu_pkg::show_name;
                if (state_reg.item == switch_menu_pkg::item_additional)
                begin
                    state_next.item = switch_menu_pkg::item_lock; // R01
                end
                else
                begin
                    state_next.item = switch_menu_pkg::menu_item_type'(4'(state_reg.item) + 4'h1);
                end
            end
        end
        else if (state_reg.mode == switch_menu_pkg::editing)
        begin
            if (press.enter)
            begin
                state_next.settings = store_value(state_reg.settings, state_reg.item,
                    state_reg.edit_level); // R05
                state_next.mode = switch_menu_pkg::show_value;
            end
            else if (press.up)
            begin
                state_next.edit_level = step_value(state_reg.item,
                    state_reg.edit_level, 1'b1); // R04
            end
            else if (press.down)
            begin
                state_next.edit_level = step_value(state_reg.item,
                    state_reg.edit_level, 1'b0); // R04
            end
        end
        else if (state_reg.mode != switch_menu_pkg::in_submenu)
        begin
            if (press.set)
            begin
                state_next.hold_count = '0;
                state_next.hold_done = 1'b0;
                if (state_reg.item == switch_menu_pkg::item_additional)
                begin
                    state_next.mode = switch_menu_pkg::in_submenu; // R17
                    state_next.hold_done = 1'b1;
                end
            end
            else if (state_reg.sync2.set && !state_reg.hold_done)
            begin
                if (state_reg.hold_count == HOLD_LAST)
                begin
                    state_next.hold_done = 1'b1;
                    state_next.mode = switch_menu_pkg::show_value;
                    if (edit_allowed)
                    begin
                        state_next.mode = switch_menu_pkg::editing; // R03 R07
                        state_next.edit_level = item_value(state_reg.settings, state_reg.item);
                    end
                end
                else
                begin
                    state_next.hold_count = state_reg.hold_count + 28'h000_0001;
                end
            end
            else if (set_release && !state_reg.hold_done)
            begin
                state_next.mode = switch_menu_pkg::show_value; // R02
                state_next.hold_done = 1'b1;
            end
        end

        // Avalon slave: answer on the edge after the request appears
        state_next.ack = req && !state_reg.ack;
        if (req && !state_reg.ack)
        begin
            state_next.rdata = '0;
            if (write && address == `CONTROL_OFFSET && byteenable[0])
            begin
                state_next.settings.menu_editable_state =
                    writedata[`CONTROL_EDITABLE_BIT]; // R06
            end
            else if (read)
            begin
                if (address == `CONTROL_OFFSET)
                begin
                    state_next.rdata[`CONTROL_EDITABLE_BIT] =
                        state_reg.settings.menu_editable_state;
                end
                else if (address == `STATUS_OFFSET)
                begin
                    state_next.rdata[`STATUS_ITEM_LSB +: 4] = state_reg.item;
                    state_next.rdata[`STATUS_MODE_LSB +: 2] = state_reg.mode;
                    state_next.rdata[`STATUS_OUT1_BIT] = first_output;
                    state_next.rdata[`STATUS_OUT2_BIT] = second_output;
                    state_next.rdata[`STATUS_EDITABLE_BIT] =
                        state_reg.settings.menu_editable_state;
                end
                else if (address == `FUNCTIONS_OFFSET)
                begin
                    state_next.rdata[1:0] = state_reg.settings.first_output_function;
                    state_next.rdata[`FUNCTIONS_SECOND_LSB +: 2] =
                        state_reg.settings.second_output_function;
                end
                else if (address == `FIRST_HYST_OFFSET)
                begin
                    state_next.rdata = {state_reg.settings.first_release_level,
                        state_reg.settings.first_trip_level};
                end
                else if (address == `FIRST_WINDOW_OFFSET)
                begin
                    state_next.rdata = {state_reg.settings.first_window_low,
                        state_reg.settings.first_window_high};
                end
                else if (address == `SECOND_HYST_OFFSET)
                begin
                    state_next.rdata = {state_reg.settings.second_release_level,
                        state_reg.settings.second_trip_level};
                end
                else if (address == `SECOND_WINDOW_OFFSET)
                begin
                    state_next.rdata = {state_reg.settings.second_window_low,
                        state_reg.settings.second_window_high};
                end
                else if (address == `ANALOG_OFFSET)
                begin
                    state_next.rdata = {state_reg.settings.analog_end_level,
                        state_reg.settings.analog_start_level};
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.settings.menu_editable_state <= `EDITABLE_RESET; // R06
            state_reg.settings.first_trip_level <= TRIP_DEFAULT; // R09
            state_reg.settings.first_release_level <= RELEASE_DEFAULT; // R10
            state_reg.settings.first_window_high <= TRIP_DEFAULT; // R11
            state_reg.settings.first_window_low <= RELEASE_DEFAULT; // R11
            state_reg.settings.second_trip_level <= TRIP_DEFAULT; // R13
            state_reg.settings.second_release_level <= RELEASE_DEFAULT; // R13
            state_reg.settings.second_window_high <= TRIP_DEFAULT; // R14
            state_reg.settings.second_window_low <= RELEASE_DEFAULT; // R14
            state_reg.settings.analog_start_level <= START_DEFAULT; // R15
            state_reg.settings.analog_end_level <= END_DEFAULT; // R16
            state_reg.hold_done <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    level_switch first_switch
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .pressure(pressure_level),
        .func(state_reg.settings.first_output_function),
        .trip(state_reg.settings.first_trip_level),
        .release_level(state_reg.settings.first_release_level),
        .window_high(state_reg.settings.first_window_high),
        .window_low(state_reg.settings.first_window_low),
        .switch_out(first_output)
    );

    level_switch second_switch
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .pressure(pressure_level),
        .func(state_reg.settings.second_output_function),
        .trip(state_reg.settings.second_trip_level),
        .release_level(state_reg.settings.second_release_level),
        .window_high(state_reg.settings.second_window_high),
        .window_low(state_reg.settings.second_window_low),
        .switch_out(second_output)
    );

    assign waitrequest = (read | write) & ~state_reg.ack;
    assign readdata = state_reg.rdata;
    assign display.item = state_reg.item;
    assign display.value = (state_reg.mode == switch_menu_pkg::editing) ?
        state_reg.edit_level : item_value(state_reg.settings, state_reg.item);
    assign display.flashing = (state_reg.mode == switch_menu_pkg::show_value); // R03
    assign display.editing = (state_reg.mode == switch_menu_pkg::editing);
    assign display.locked = ~state_reg.settings.menu_editable_state; // R07
    assign display.submenu = (state_reg.mode == switch_menu_pkg::in_submenu);

endmodule : pressure_switch_menu

// ===== hw/switch_menu_regs.svh
// Register offsets, field positions, reset values and timing counts of the switch menu.
// Assumes a 50 MHz ref_clk and pressure levels in signed counts of full scale.
// Notes on behaviour
// R01: Mode press steps to next menu item
// R02: Short set press shows value, no edit
// R03: Set held five seconds enters steady edit
// R04: Up increments, down decrements edited value
// R05: Enter stores edited value as active
// R06: Lock editable after reset unless operator locks
// R07: Locked menu shows indication, refuses edits
// R08: Output one offers four function choices
// R09: Output one trips rising, default half scale
// R10: Output one releases falling, default quarter
// R11: Output one window limits default 50/25
// R12: Output two offers same four choices
// R13: Output two own trip/release, 50/25 defaults
// R14: Output two own window limits, 50/25
// R15: Analog start default -1 vacuum, else 0
// R16: Analog end default is range top
// R17: Set on extra entry opens sub-menu
// R18: Keep half percent between trip, release
// R19: Trip change drags release to stay valid
// R20: Analog start, end ten percent apart
// R21: Normally closed inverts normally open output
// R22: Window open active between low, high limits
// R23: Leaving edit without enter discards value
`ifndef SWITCH_MENU_REGS_SVH
`define SWITCH_MENU_REGS_SVH

`define CONTROL_OFFSET 5'h00
`define STATUS_OFFSET 5'h04
`define FUNCTIONS_OFFSET 5'h08
`define FIRST_HYST_OFFSET 5'h0C
`define FIRST_WINDOW_OFFSET 5'h10
`define SECOND_HYST_OFFSET 5'h14
`define SECOND_WINDOW_OFFSET 5'h18
`define ANALOG_OFFSET 5'h1C

`define CONTROL_EDITABLE_BIT 0
`define STATUS_ITEM_LSB 0
`define STATUS_MODE_LSB 4
`define STATUS_OUT1_BIT 8
`define STATUS_OUT2_BIT 9
`define STATUS_EDITABLE_BIT 10
`define FUNCTIONS_SECOND_LSB 2
`define PAIR_HIGH_LSB 16

`define EDITABLE_RESET 1'b1
`define TRIP_DEFAULT_PCT 50
`define RELEASE_DEFAULT_PCT 25
`define HYST_MIN_PERMILLE 5
`define ANALOG_SPAN_MIN_PCT 10

`define CLK_KHZ 50000
`define SET_HOLD_MS 5000
`define SET_HOLD_CYCLES (`SET_HOLD_MS * `CLK_KHZ)

`endif

// ===== hw/switch_menu_pkg.sv
// Types shared by the switch menu and its output evaluators.
// Assumes levels fit 16 signed bits.
package switch_menu_pkg;

    typedef logic signed [15:0] level_type;

    typedef enum logic [1:0] {
        hyst_open,
        hyst_closed,
        window_open,
        window_closed
    } function_type;

    typedef enum logic [3:0] {
        item_lock,
        item_first_function,
        item_first_trip,
        item_first_release,
        item_first_window_high,
        item_first_window_low,
        item_second_function,
        item_second_trip,
        item_second_release,
        item_second_window_high,
        item_second_window_low,
        item_analog_start,
        item_analog_end,
        item_additional
    } menu_item_type;

    typedef enum logic [1:0] {
        show_name,
        show_value,
        editing,
        in_submenu
    } menu_mode_type;

    typedef struct packed {
        logic mode;
        logic set;
        logic up;
        logic down;
        logic enter;
    } button_type;

    typedef struct packed {
        logic menu_editable_state;
        function_type first_output_function;
        level_type first_trip_level;
        level_type first_release_level;
        level_type first_window_high;
        level_type first_window_low;
        function_type second_output_function;
        level_type second_trip_level;
        level_type second_release_level;
        level_type second_window_high;
        level_type second_window_low;
        level_type analog_start_level;
        level_type analog_end_level;
    } settings_type;

    typedef struct packed {
        menu_item_type item;
        level_type value;
        logic flashing;
        logic editing;
        logic locked;
        logic submenu;
    } display_type;

endpackage : switch_menu_pkg

// ===== hw/level_switch.sv
// One switching output: hysteresis or window, normally open or closed.
// Assumes pressure and levels on the same clock as the menu.
`timescale 1ns/1ps
module level_switch
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire switch_menu_pkg::level_type pressure,
    input wire switch_menu_pkg::function_type func,
    input wire switch_menu_pkg::level_type trip,
    input wire switch_menu_pkg::level_type release_level,
    input wire switch_menu_pkg::level_type window_high,
    input wire switch_menu_pkg::level_type window_low,
    output logic switch_out
);
    typedef struct packed {
        logic hyst_on;
        logic out;
    } state_type;

    state_type state_reg;
    state_type state_next;

    always_comb
    begin
        logic open_level;
        open_level = 1'b0;
        state_next = state_reg;
        // Between the two levels the last decision holds
        if (pressure >= trip)
        begin
            state_next.hyst_on = 1'b1; // R09 R13
        end
        else if (pressure <= release_level)
        begin
            state_next.hyst_on = 1'b0; // R10 R13
        end
        if (func == switch_menu_pkg::hyst_open || func == switch_menu_pkg::hyst_closed)
        begin
            open_level = state_next.hyst_on;
        end
        else
        begin
            open_level = (pressure >= window_low) && (pressure <= window_high); // R11 R14 R22
        end
        if (func == switch_menu_pkg::hyst_closed || func == switch_menu_pkg::window_closed)
        begin
            state_next.out = ~open_level; // R21
        end
        else
        begin
            state_next.out = open_level;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign switch_out = state_reg.out;

endmodule : level_switch

// ===== dv/pressure_switch_menu_assertions.sv
// Port checker for the pressure switch menu.
// Assumes buttons are held at least two cycles.
`timescale 1ns/1ps
module menu_checker
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire switch_menu_pkg::button_type buttons,
    input wire switch_menu_pkg::display_type display
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bus_wait:
        assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest) else $error("wait");
    a_mode_step:
        assert property ($rose(buttons.mode) && !display.editing && !display.submenu |-> ##[1:5]
            $changed(display.item)) else $error("no step");
    a_short_set:
        assert property ($fell(buttons.set) && !display.flashing && !display.editing
            && display.item != 4'hd |-> ##[1:5] display.flashing) else $error("no value");
    a_edit_steady:
        assert property (display.editing |-> !display.flashing) else $error("flashing");
    a_up_counts:
        assert property (display.editing && $rose(buttons.up | buttons.down) |-> ##[1:5]
            $changed(display.value)) else $error("no count");
    a_lock_reset:
        assert property ($fell(rst) |-> !display.locked) else $error("locked");
    a_locked_edit:
        assert property (display.editing && display.locked |-> display.item == 4'h0)
            else $error("edit locked");
    a_sub_item:
        assert property (display.submenu |-> display.item == 4'hd) else $error("sub");
    cover property (display.editing);
    cover property (display.submenu);
    cover property (display.locked);
endmodule : menu_checker
bind pressure_switch_menu menu_checker chk (.ref_clk(ref_clk), .rst(rst), .read(read),
    .write(write), .waitrequest(waitrequest), .buttons(buttons), .display(display));

// ===== dv/operator_model.sv
// Operator buttons and pressure source.
// Assumes the menu settles within eight cycles of a release.
`timescale 1ns/1ps
module operator_model
(
    input wire logic ref_clk,
    output switch_menu_pkg::button_type buttons,
    output switch_menu_pkg::level_type pressure
);
    initial buttons = '0;
    initial pressure = '0;
    task automatic press(input int b, input int hold);
        @(posedge ref_clk);
        buttons <= 5'h10 >> b;
        repeat (hold) @(posedge ref_clk);
        buttons <= '0;
        repeat (8) @(posedge ref_clk);
    endtask : press
    task automatic level(input int p);
        @(posedge ref_clk);
        pressure <= switch_menu_pkg::level_type'(p);
        repeat (4) @(posedge ref_clk);
    endtask : level
endmodule : operator_model

// ===== dv/tb_pressure_switch_menu.sv
// Bench for the pressure switch menu.
// Assumes the operator model drives buttons and pressure.
`timescale 1ns/1ps
module tb_pressure_switch_menu;
    localparam int HOLD = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic first_output;
    logic second_output;
    switch_menu_pkg::button_type buttons;
    switch_menu_pkg::level_type pressure;
    switch_menu_pkg::display_type display;
    int mismatches = 0;
    int checks = 0;
    int seed = 55;
    int item = 0;
    int h = 0;
    int p;
    always #10 ref_clk = ~ref_clk;
    pressure_switch_menu #(.HOLD_CYCLES(HOLD)) uut (.ref_clk(ref_clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .buttons(buttons), .pressure_level(pressure), .first_output(first_output),
        .second_output(second_output), .display(display));
    operator_model op (.ref_clk(ref_clk), .buttons(buttons), .pressure(pressure));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // Reads compare with d; writes send d
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge ref_clk); while (waitrequest);
        if (!wr)
            cmp(readdata, d);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic go(input int t);
        while (item != t)
        begin
            op.press(0, 2);
            item = (item + 1) % 14;
            cmp(display.item, item);
        end
    endtask : go
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    initial
    begin
        #2ms;
        mismatches++;
        wrap_up();
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 12; a < 28; a += 4)
            bus(0, 5'(a), 32'h09C4_1388);
        bus(0, 5'h1C, 32'h2710_0000);
        $display("defaults done");
        go(1);
        for (int f = 0; f < 4; f++)
        begin
            if (f > 0)
            begin
                op.press(1, HOLD + 8);
                cmp(display.editing, 1);
                op.press(2, 2);
                op.press(4, 2);
            end
            for (int k = 0; k < 9; k++)
            begin
                p = k ? (($random(seed) & 63) * 150) : 6000;
                op.level(p);
                h = p >= 5000 ? 1 : (p <= 2500 ? 0 : h);
                cmp(first_output, (f[1] ? p >= 2500 && p <= 5000 : h) ^ f[0]);
                cmp(second_output, h);
            end
            bus(0, 5'h08, f);
        end
        $display("functions done");
        go(2);
        op.press(1, 2);
        cmp(display.flashing, 1);
        op.press(1, HOLD + 8);
        op.press(2, 2);
        op.press(0, 2);
        bus(0, 5'h0C, 32'h09C4_1388);
        bus(1, 5'h00, 0);
        op.press(1, HOLD + 8);
        cmp({display.locked, display.editing}, 2);
        bus(1, 5'h00, 1);
        bus(0, 5'h00, 1);
        op.press(1, HOLD + 8);
        op.press(3, 2);
        op.press(4, 2);
        bus(0, 5'h0C, 32'h09C4_1387);
        go(13);
        op.press(1, 2);
        cmp(display.submenu, 1);
        $display("menu done");
        wrap_up();
    end
endmodule : tb_pressure_switch_menu
